/* rtl/cache_ctrl_defines.vh */
// Function
// - Coherency one: program drops every line.
// - Coherency zero: keep locked instruction lines.
// - Data line count: off, 1, 2, 4.
// - Data count change invalidates every line.
// - Prefetch region: off, cacheable, uncacheable, both.
// - Wait states equal field binary value.
`ifndef CACHE_CTRL_DEFINES_VH
`define CACHE_CTRL_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
// Byte address of the configuration word.
`define CFG_OFFSET          12'h000
// Writable and readable bits of the configuration word.
`define CFG_IMPL_MASK       32'h0001_0337
// Reset value: seven wait states, all else off.
`define CFG_RESET           32'h0000_0007

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_COHERENCY_BIT   16
`define CFG_DLINES_HI       9
`define CFG_DLINES_LO       8
`define CFG_PREFETCH_HI     5
`define CFG_PREFETCH_LO     4
`define CFG_WAIT_HI         2
`define CFG_WAIT_LO         0

// ****************************************************************
// Encodings and sizes
// ****************************************************************
`define DLINES_OFF          2'h0
`define DLINES_ONE          2'h1
`define DLINES_TWO          2'h2
`define DLINES_FOUR         2'h3
`define PREFETCH_OFF        2'h0
`define PREFETCH_CACHEABLE  2'h1
`define PREFETCH_UNCACHED   2'h2
`define PREFETCH_BOTH       2'h3
`define DATA_LINES_MAX      4
`define INSTR_LINES_DEF     16

`endif

/* rtl/line_valid_array.v */
`timescale 1ns/100ps
// Valid state of every instruction and data line, and lock state of every instruction line.
module line_valid_array #(
    parameter INSTR_LINES = 16,
    parameter IDX_W       = 4
) (
    input  wire                   i_clk,
    input  wire                   i_rst,
    input  wire                   i_inv_all,
    input  wire                   i_inv_unlocked,
    input  wire                   i_instr_fill,
    input  wire [IDX_W-1:0]       i_instr_index,
    input  wire                   i_instr_lock,
    input  wire                   i_data_fill,
    input  wire [1:0]             i_data_index,
    input  wire [2:0]             i_data_count,
    output reg  [INSTR_LINES-1:0] o_instr_valid,
    output reg  [INSTR_LINES-1:0] o_instr_locked,
    output reg  [3:0]             o_data_valid
);

    // ****************************************************************
    // Instruction lines
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < INSTR_LINES; g = g + 1) begin : g_instr
            // One line: invalidation outranks a fill in the same cycle.
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_instr_valid[g]  <= 1'b0;
                    o_instr_locked[g] <= 1'b0;
                end else if (i_inv_all) begin
                    o_instr_valid[g]  <= 1'b0;
                    o_instr_locked[g] <= 1'b0;
                end else if (i_inv_unlocked && !o_instr_locked[g]) begin
                    o_instr_valid[g]  <= 1'b0;
                end else if (i_instr_fill && (i_instr_index == g)) begin
                    o_instr_valid[g]  <= 1'b1;
                    o_instr_locked[g] <= i_instr_lock;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Data lines
    // ****************************************************************
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_data
            // A data line fills only when it lies inside the enabled count.
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_data_valid[g] <= 1'b0;
                end else if (i_inv_all || i_inv_unlocked) begin
                    o_data_valid[g] <= 1'b0;
                end else if (i_data_fill && (i_data_index == g) && (g < i_data_count)) begin
                    o_data_valid[g] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule // line_valid_array

/* rtl/flash_wait_timer.v */
`timescale 1ns/100ps
// Stretches one flash array access by the programmed wait states.
module flash_wait_timer (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_start,
    input  wire [2:0] i_wait_states,
    output reg        o_busy,
    output reg        o_done
);

    reg [2:0] count;  // Wait states still to run.

    // Loads on a start, counts down, and pulses done after the last wait.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count  <= 3'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (!o_busy) begin
            o_done <= 1'b0;
            if (i_start) begin
                count  <= i_wait_states;
                o_busy <= 1'b1;
            end
        end else if (count == 3'h0) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
        end else begin
            count  <= count - 3'h1;
        end
    end

endmodule // flash_wait_timer

/* rtl/flash_prefetch_cache_control.v */
`timescale 1ns/100ps
`include "cache_ctrl_defines.vh"
// Configuration and line control for the prefetch and data cache.
module flash_prefetch_cache_control #(
    parameter INSTR_LINES = `INSTR_LINES_DEF,
    parameter IDX_W       = 4
) (
    input  wire                   i_clk,
    input  wire                   i_rst,
    // AHB-Lite slave port.
    input  wire                   i_hsel,
    input  wire [31:0]            i_haddr,
    input  wire [1:0]             i_htrans,
    input  wire                   i_hwrite,
    input  wire [2:0]             i_hsize,
    input  wire                   i_hready,
    input  wire [31:0]            i_hwdata,
    output reg  [31:0]            o_hrdata,
    output wire                   o_hreadyout,
    output wire                   o_hresp,
    // Flash programming and fetch side.
    input  wire                   i_program_cycle,
    input  wire                   i_instr_fill,
    input  wire [IDX_W-1:0]       i_instr_index,
    input  wire                   i_instr_lock,
    input  wire                   i_data_fill,
    input  wire [1:0]             i_data_index,
    input  wire                   i_access_cacheable,
    input  wire                   i_flash_start,
    output wire [INSTR_LINES-1:0] o_instr_valid,
    output wire [INSTR_LINES-1:0] o_instr_locked,
    output wire [3:0]             o_data_valid,
    output reg  [2:0]             o_data_count,
    output reg                    o_prefetch_allow,
    output reg  [2:0]             o_wait_states,
    output wire                   o_flash_busy,
    output wire                   o_flash_done
);

    // ****************************************************************
    // Decode functions
    // ****************************************************************

    // Number of data lines that a line count selector enables.
    function [2:0] line_count;
        input [1:0] sel;
        begin
            case (sel)
                `DLINES_ONE:  line_count = 3'h1;
                `DLINES_TWO:  line_count = 3'h2;
                `DLINES_FOUR: line_count = 3'h4;
                default:      line_count = 3'h0;
            endcase
        end
    endfunction

    // Whether prefetch runs for a region of the given kind.
    function prefetch_on;
        input [1:0] sel;
        input       cacheable;
        begin
            case (sel)
                `PREFETCH_CACHEABLE: prefetch_on = cacheable;
                `PREFETCH_UNCACHED:  prefetch_on = !cacheable;
                `PREFETCH_BOTH:      prefetch_on = 1'b1;
                default:             prefetch_on = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    reg  [31:0] config_word;   // Stored configuration word.
    reg         wr_pending;    // A write data phase follows.
    reg         wr_hit;        // That write targets the configuration word.
    wire        addr_phase;    // A valid transfer is taken this cycle.
    wire        cfg_hit;       // The address phase targets the word.
    wire [31:0] wr_value;      // Write data kept to implemented bits.
    wire        cfg_write;     // The word is written this cycle.
    wire        dlines_change; // The write alters the data line count.

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign addr_phase  = i_hsel && i_hready && i_htrans[1];
    assign cfg_hit     = (i_haddr[11:2] == `CFG_OFFSET >> 2) && (i_haddr[1:0] == 2'h0);

    // Captures the address phase so that the write lands in its data phase.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pending <= 1'b0;
            wr_hit     <= 1'b0;
        end else begin
            wr_pending <= addr_phase && i_hwrite;
            wr_hit     <= addr_phase && i_hwrite && cfg_hit;
        end
    end

    // Read data for the next data phase; unmapped addresses read zero.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite && cfg_hit) begin
            // A write that lands at this edge is passed on, so a read right after it sees it.
            o_hrdata <= cfg_write ? wr_value : config_word;
        end else begin
            o_hrdata <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Configuration word
    // ****************************************************************
    // unimplemented bits dropped
    assign wr_value  = i_hwdata & `CFG_IMPL_MASK;
    assign cfg_write = wr_pending && wr_hit;
    assign dlines_change = cfg_write &&
        (wr_value[`CFG_DLINES_HI:`CFG_DLINES_LO] !=
         config_word[`CFG_DLINES_HI:`CFG_DLINES_LO]);

    // Holds the configuration; reset gives seven wait states.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            config_word <= `CFG_RESET;
        end else if (cfg_write) begin
            config_word <= wr_value;
        end
    end

    // ****************************************************************
    // Decoded controls
    // ****************************************************************
    // Registers the decoded fields so the outputs come from flip-flops.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_count     <= 3'h0;
            o_prefetch_allow <= 1'b0;
            o_wait_states    <= 3'h7;
        end else begin
            o_data_count     <= line_count(config_word[`CFG_DLINES_HI:`CFG_DLINES_LO]);
            o_prefetch_allow <= prefetch_on(config_word[`CFG_PREFETCH_HI:`CFG_PREFETCH_LO],
                                            i_access_cacheable);
            o_wait_states    <= config_word[`CFG_WAIT_HI:`CFG_WAIT_LO];
        end
    end

    // ****************************************************************
    // Invalidation
    // ****************************************************************
    wire inv_all;       // Every line, locked or not, goes invalid.
    wire inv_unlocked;  // Data lines and unlocked instruction lines go invalid.
    wire coherency;     // Coherency selector.

    assign coherency    = config_word[`CFG_COHERENCY_BIT];
    assign inv_all      = (i_program_cycle && coherency) || dlines_change;
    assign inv_unlocked = i_program_cycle && !coherency;

    // Line state store.
    line_valid_array #(
        .INSTR_LINES    (INSTR_LINES),
        .IDX_W          (IDX_W)
    ) u_lines (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_inv_all      (inv_all),
        .i_inv_unlocked (inv_unlocked),
        .i_instr_fill   (i_instr_fill),
        .i_instr_index  (i_instr_index),
        .i_instr_lock   (i_instr_lock),
        .i_data_fill    (i_data_fill),
        .i_data_index   (i_data_index),
        .i_data_count   (o_data_count),
        .o_instr_valid  (o_instr_valid),
        .o_instr_locked (o_instr_locked),
        .o_data_valid   (o_data_valid)
    );

    // Flash access wait state sequencer.
    flash_wait_timer u_wait (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_start       (i_flash_start),
        .i_wait_states (config_word[`CFG_WAIT_HI:`CFG_WAIT_LO]),
        .o_busy        (o_flash_busy),
        .o_done        (o_flash_done)
    );

endmodule // flash_prefetch_cache_control

/* verification/core_fetch_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// Fetch path of the core and the flash programming strobe.
// ****************************************************************
module core_fetch_model #(
    parameter IDX_W = 4
) (
    input  wire             i_clk,
    output reg              o_instr_fill,
    output reg [IDX_W-1:0]  o_instr_index,
    output reg              o_instr_lock,
    output reg              o_data_fill,
    output reg [1:0]        o_data_index,
    output reg              o_flash_start,
    output reg              o_program_cycle
);
    // All strobes are idle from time zero.
    initial begin
        {o_program_cycle, o_flash_start, o_data_fill, o_instr_fill} = 4'h0;
        o_instr_index = {IDX_W{1'b0}};
        {o_instr_lock, o_data_index} = 3'h0;
    end

    // One-cycle pulse of the strobes in kind; the index lines scramble after it.
    task pulse(input [3:0] kind, input [IDX_W-1:0] idx, input lk);
        begin
            @(posedge i_clk);
            {o_program_cycle, o_flash_start, o_data_fill, o_instr_fill} <= kind;
            o_instr_index <= idx;
            o_data_index  <= idx[1:0];
            o_instr_lock  <= lk;
            @(posedge i_clk);
            {o_program_cycle, o_flash_start, o_data_fill, o_instr_fill} <= 4'h0;
            o_instr_index <= ~idx;
            o_data_index  <= ~idx[1:0];
            o_instr_lock  <= ~lk;
        end
    endtask
endmodule // core_fetch_model

/* verification/cache_ctrl_monitor.sv */
`timescale 1ns/100ps
// ****************************************************************
// Port checker of the cache control block.
// ****************************************************************
module cache_ctrl_monitor #(
    parameter INSTR_LINES = 16
) (
    input wire                   i_clk,
    input wire                   i_rst,
    input wire                   i_hsel,
    input wire [31:0]            i_haddr,
    input wire [1:0]             i_htrans,
    input wire                   i_hwrite,
    input wire                   i_hready,
    input wire [31:0]            i_hwdata,
    input wire                   i_program_cycle,
    input wire                   i_instr_fill,
    input wire                   i_access_cacheable,
    input wire                   i_flash_start,
    input wire [INSTR_LINES-1:0] o_instr_valid,
    input wire [INSTR_LINES-1:0] o_instr_locked,
    input wire [3:0]             o_data_valid,
    input wire [2:0]             o_data_count,
    input wire                   o_prefetch_allow,
    input wire [2:0]             o_wait_states,
    input wire                   o_flash_busy,
    input wire                   o_flash_done
);
    reg        wr_pend; // A config write is in its data phase.
    reg [31:0] wlast;   // Last word written.
    reg [3:0]  bcnt;    // Busy cycles since the accepted start.
    reg [2:0]  ws_l;    // Wait states at the accepted start.

    // Line count that a selector value gives.
    function [2:0] dc(input [1:0] s);
        dc = (s == 2'h3) ? 3'h4 : {1'b0, s};
    endfunction

    // Tracks config writes and flash accesses.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pend <= 1'b0;
            wlast <= 32'h0000_0007;
            bcnt <= 4'h0;
            ws_l <= 3'h0;
        end else begin
            wr_pend <= i_hsel & i_hready & i_htrans[1] & i_hwrite & (i_haddr[11:0] == 12'h000);
            if (wr_pend) begin
                wlast <= i_hwdata;
            end
            if (i_flash_start && !o_flash_busy) begin
                bcnt <= 4'h0;
                ws_l <= o_wait_states;
            end else if (o_flash_busy) begin
                bcnt <= bcnt + 4'h1;
            end
        end
    end

    default clocking dclk @(posedge i_clk); endclocking
    default disable iff (i_rst);

    reset_state_a: assert property ($fell(i_rst) |-> o_wait_states == 3'h7 && o_data_count == 3'h0)
        else $error("bad state after reset");
    line_count_a: assert property (wr_pend |=> ##[0:1] o_data_count == dc(wlast[9:8]))
        else $error("data line count wrong");
    wait_copy_a: assert property (wr_pend |=> ##[0:1] o_wait_states == wlast[2:0])
        else $error("wait states wrong");
    resize_clear_a: assert property (wr_pend && dc(i_hwdata[9:8]) != o_data_count |=>
        o_data_valid == 4'h0 && o_instr_valid == {INSTR_LINES{1'b0}})
        else $error("lines survive a resize");
    coh_all_a: assert property (i_program_cycle && wlast[16] |=> o_data_valid == 4'h0 &&
        o_instr_valid == {INSTR_LINES{1'b0}} && o_instr_locked == {INSTR_LINES{1'b0}})
        else $error("lines survive a program cycle");
    coh_keep_a: assert property (i_program_cycle && !wlast[16] && !i_instr_fill |=>
        o_data_valid == 4'h0 && o_instr_valid == $past(o_instr_valid & o_instr_locked))
        else $error("locked lines not kept");
    flash_len_a: assert property (o_flash_done |-> bcnt == {1'b0, ws_l} + 4'h1)
        else $error("flash access length wrong");
    flash_go_a: assert property (i_flash_start && !o_flash_busy |=> o_flash_busy)
        else $error("flash start not taken");
    prefetch_a: assert property (o_prefetch_allow == ($past(i_access_cacheable) ?
        $past(wlast[4]) : $past(wlast[5])))
        else $error("prefetch allow wrong");

    cover property (i_program_cycle && wlast[16]);
    cover property (o_flash_done && ws_l == 3'h7);
    cover property (wr_pend && i_hwdata[9:8] == 2'h3);
endmodule // cache_ctrl_monitor

bind flash_prefetch_cache_control cache_ctrl_monitor #(.INSTR_LINES(INSTR_LINES)) i_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .i_hwdata(i_hwdata),
    .i_program_cycle(i_program_cycle), .i_instr_fill(i_instr_fill),
    .i_access_cacheable(i_access_cacheable), .i_flash_start(i_flash_start),
    .o_instr_valid(o_instr_valid), .o_instr_locked(o_instr_locked),
    .o_data_valid(o_data_valid), .o_data_count(o_data_count),
    .o_prefetch_allow(o_prefetch_allow), .o_wait_states(o_wait_states),
    .o_flash_busy(o_flash_busy), .o_flash_done(o_flash_done));

/* verification/flash_prefetch_cache_control_test.sv */
`timescale 1ns/100ps
`include "cache_ctrl_defines.vh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
// ****************************************************************
// Bench of the cache control block.
// ****************************************************************
module flash_prefetch_cache_control_test;
    reg         i_clk = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cacheable = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    reg  [1:0]  htrans = 2'h0;
    wire [31:0] hrdata;
    wire [15:0] ivalid, ilocked;
    wire [3:0]  dvalid, iidx;
    wire [2:0]  dcount, wstates;
    wire [1:0]  didx;
    wire        hready, hresp, allow, busy, done, ifill, ilock, dfill, fstart, prog;
    integer     miscompares = 0, n_compared = 0;

    always #50 i_clk = ~i_clk;

    core_fetch_model i_core_fetch_model (.i_clk(i_clk), .o_instr_fill(ifill),
        .o_instr_index(iidx), .o_instr_lock(ilock), .o_data_fill(dfill),
        .o_data_index(didx), .o_flash_start(fstart), .o_program_cycle(prog));
    flash_prefetch_cache_control i_flash_prefetch_cache_control (.i_clk(i_clk),
        .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_program_cycle(prog), .i_instr_fill(ifill),
        .i_instr_index(iidx), .i_instr_lock(ilock), .i_data_fill(dfill),
        .i_data_index(didx), .i_access_cacheable(cacheable), .i_flash_start(fstart),
        .o_instr_valid(ivalid), .o_instr_locked(ilocked), .o_data_valid(dvalid),
        .o_data_count(dcount), .o_prefetch_allow(allow), .o_wait_states(wstates),
        .o_flash_busy(busy), .o_flash_done(done));

    // Prints the verdict and ends the run.
    task summarize;
        begin
            if (miscompares == 0 && n_compared > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    // Waits for hready under a bound; a hang ends the run.
    task wait_ready;
        integer n;
        begin
            n = 0;
            do begin @(posedge i_clk); n = n + 1; end while (hready !== 1'b1 && n < 20);
            if (hready !== 1'b1) begin miscompares++; summarize; end
        end
    endtask

    // One single word transfer; read data lands in q.
    task ahb(input wr, input [31:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
            wait_ready;
            {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
            wait_ready;
            q = hrdata;
        end
    endtask

    // Lets k edges pass and steps off the edge.
    task settle(input integer k);
        begin repeat (k) @(posedge i_clk); #1; end
    endtask

    // Reset value, and an unmapped write that must not land.
    task t_reset;
        begin
            ahb(0, 32'h0, 32'h0);
            `CHK(q, `CFG_RESET)
            `CHK({dcount, allow, wstates}, 7'h07)
            `CHK(hresp, 1'b0)
            ahb(1, 32'h10, 32'h0000_0330);
            ahb(0, 32'h0, 32'h0);
            `CHK(q, `CFG_RESET)
        end
    endtask

    // Every selector code, wait fields 7, 5, 3 and 1, and both region kinds.
    task t_fields;
        integer s, c;
        reg [31:0] w;
        begin
            for (s = 0; s < 4; s = s + 1) begin
                w = {22'h0, s[1:0], 2'h0, s[1:0], 1'b0, 3'h7 - {s[1:0], 1'b0}};
                ahb(1, 32'h0, w);
                ahb(0, 32'h0, 32'h0);
                `CHK(q, w)
                settle(1);
                `CHK(dcount, (s == 3) ? 3'h4 : s[2:0])
                `CHK(wstates, w[2:0])
                for (c = 0; c < 2; c = c + 1) begin
                    @(posedge i_clk);
                    cacheable <= c[0];
                    settle(2);
                    `CHK(allow, c[0] ? w[4] : w[5])
                end
            end
        end
    endtask

    // Flash access length at zero and seven wait states.
    task t_flash;
        integer ws, n, k;
        begin
            for (ws = 0; ws < 8; ws = ws + 7) begin
                ahb(1, 32'h0, ws);
                settle(1);
                i_core_fetch_model.pulse(4'h4, 4'h0, 1'b0);
                n = 0;
                k = 0;
                do begin @(posedge i_clk); k++; n += (busy === 1'b1); end
                    while (done !== 1'b1 && k < 20);
                // A hung access counts as a mismatch and ends the run.
                if (done !== 1'b1) begin miscompares++; summarize; end
                `CHK(n, ws + 1)
            end
        end
    endtask

    // Program cycle with coherency c over locked, unlocked and data lines.
    task t_inval(input c);
        begin
            ahb(1, 32'h0, {15'h0, c, 8'h03, 8'h07});
            settle(2);
            i_core_fetch_model.pulse(4'h1, 4'h3, 1'b1);
            i_core_fetch_model.pulse(4'h1, 4'h5, 1'b0);
            i_core_fetch_model.pulse(4'h2, 4'h1, 1'b0);
            i_core_fetch_model.pulse(4'h8, 4'h0, 1'b0);
            settle(1);
            `CHK({ivalid, ilocked, dvalid}, c ? 36'h0 : {16'h0008, 16'h0008, 4'h0})
        end
    endtask

    // Resize drops the locked line; one line accepts only index 0.
    task t_resize;
        begin
            ahb(1, 32'h0, 32'h0000_0107);
            settle(2);
            `CHK({ivalid, ilocked, dvalid}, 36'h0)
            i_core_fetch_model.pulse(4'h2, 4'h1, 1'b0);
            i_core_fetch_model.pulse(4'h2, 4'h0, 1'b0);
            settle(1);
            `CHK(dvalid, 4'h1)
        end
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset;
        t_fields;
        t_flash;
        t_inval(1'b1);
        t_inval(1'b0);
        t_resize;
        summarize;
    end
endmodule // flash_prefetch_cache_control_test
